// ### pwmc_top.v
// six-channel left-aligned modulator with pair joining, apb registers
// Notes on behaviour
// - join_pair_hi makes 4/5 one 16-bit channel
// - join_pair_mid makes 2/3 one 16-bit channel
// - join_pair_lo makes 0/1 one 16-bit channel
// - unjoined pairs run as independent 8-bit channels
// - joined channel uses odd channel's control bits
// - wait_stop_bit gates prescaler during wait mode
// - freeze_stop_bit gates prescaler during freeze mode
// - registers stay accessible; clock resumes on clear/exit
// - duty match toggles the output flip-flop
// - period match resets counter and output
// - period match loads buffered period and duty
// - counter runs zero to period minus one
// - output frequency is clock over period
// - high time follows polarity formula
// - factory test register hidden from software
`timescale 1ns/1ps
`include "pwmc_consts.vh"
module pwmc_top #(
	parameter NCH    = 6,
	parameter ADDR_W = 8
) (
	input  wire              clk,
	input  wire              resetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata_r,
	output reg               pready_r,
	output reg               pslverr_r,
	input  wire              wait_mode,
	input  wire              freeze_mode,
	output reg  [NCH-1:0]    pwm_out_r
);

	// software-visible state
	reg  [NCH-1:0] enable_r;
	reg  [NCH-1:0] polar_r;
	reg  [NCH-1:0] clksel_r;
	reg  [7:0]     prescale_r;
	reg  [7:0]     scale_a_r;
	reg  [7:0]     scale_b_r;
	reg  [7:0]     ctrl_r;
	reg  [7:0]     per_buf_r [0:NCH-1];
	reg  [7:0]     dty_buf_r [0:NCH-1];
	// active compare values and counters
	reg  [7:0]     per_act_r [0:NCH-1];
	reg  [7:0]     dty_act_r [0:NCH-1];
	reg  [7:0]     cnt_r     [0:NCH-1];
	reg  [7:0]     per_act_nxt [0:NCH-1];
	reg  [7:0]     dty_act_nxt [0:NCH-1];
	reg  [7:0]     cnt_nxt     [0:NCH-1];
	reg  [NCH-1:0] pwm_out_nxt;
	// clock sources
	reg  [7:0]     pre_cnt_r;
	reg  [8:0]     sa_cnt_r;
	reg  [8:0]     sb_cnt_r;

	wire [2:0]     join_w;
	wire           run_w;
	wire           tick_a;
	wire           tick_b;
	wire [8:0]     sa_lim;
	wire [8:0]     sb_lim;
	wire           tick_sa;
	wire           tick_sb;
	reg  [NCH-1:0] tick_ch;
	reg  [NCH-1:0] cnt_clr;

	wire           wr_en;
	wire           setup;
	wire [2:0]     grp;
	wire [2:0]     idx;
	wire           idx_ok;
	reg  [31:0]    rd_val;
	reg            rd_err;

	// one loop index per process, so no variable has two drivers
	integer        i;
	integer        it;
	integer        iw;
	integer        ic;
	integer        io;
	integer        k;
	integer        e;
	integer        o;
	reg  [48:0]    st;

	// tick when the low sel bits of the prescaler are all ones
	function fn_div;
		input [7:0] cnt;
		input [2:0] sel;
		reg   [7:0] mask;
		begin
			mask   = (8'h01 << sel) - 8'h01;
			fn_div = ((cnt & mask) == mask);
		end
	endfunction

	// scaled clock limit: twice the scale minus one, zero meaning the largest
	function [8:0] fn_lim;
		input [7:0] scl;
		begin
			if (scl == 8'h00)
				fn_lim = `PWMC_SCL_ZERO_LIM;
			else
				fn_lim = {scl, 1'b0} - 9'h001;
		end
	endfunction

	// one left-aligned step; 8-bit channels are zero-extended so
	// one path serves both joined and independent channels
	// result is {count, period, duty, out}
	function [48:0] fn_step;
		input [15:0] c;
		input [15:0] p;
		input [15:0] d;
		input [15:0] pb;
		input [15:0] db;
		input        q;
		input        tk;
		input        en;
		input        pol;
		input        clr;
		reg   [16:0] inc;
		reg   [15:0] nc;
		begin
			inc = {1'b0, c} + 17'h00001;
			nc  = inc[15:0];
			if (!en)
				fn_step = {16'h0000, pb, db, 1'b0};
			else if (clr)
				fn_step = {16'h0000, p, d, pol ^ (d == 16'h0000)};
			else if (!tk)
				fn_step = {c, p, d, q};
			else if (inc >= {1'b0, p})
				fn_step = {16'h0000, pb, db, pol ^ (db == 16'h0000)};
			else
				fn_step = {nc, p, d, (nc == d) ? ~q : q};
		end
	endfunction

	// low pair first, so join_w[k] lines up with the pair loop index
	assign join_w = {ctrl_r[`PWMC_BIT_JOIN_HI], ctrl_r[`PWMC_BIT_JOIN_MID],
		ctrl_r[`PWMC_BIT_JOIN_LO]};

	// prescaler input gated in wait or freeze; registers stay live
	assign run_w = ~((wait_mode & ctrl_r[`PWMC_BIT_WAIT]) |
		(freeze_mode & ctrl_r[`PWMC_BIT_FREEZE]));

	assign tick_a  = run_w & fn_div(pre_cnt_r,
		prescale_r[`PWMC_PRE_A_LSB+2:`PWMC_PRE_A_LSB]);
	assign tick_b  = run_w & fn_div(pre_cnt_r,
		prescale_r[`PWMC_PRE_B_LSB+2:`PWMC_PRE_B_LSB]);
	assign sa_lim  = fn_lim(scale_a_r);
	assign sb_lim  = fn_lim(scale_b_r);
	assign tick_sa = tick_a & (sa_cnt_r == sa_lim);
	assign tick_sb = tick_b & (sb_cnt_r == sb_lim);

	// counters hold rather than clear, so timing resumes in place
	always @(posedge clk) begin
		if (!resetn) begin
			pre_cnt_r <= 8'h00;
			sa_cnt_r  <= 9'h000;
			sb_cnt_r  <= 9'h000;
		end else begin
			if (run_w)
				pre_cnt_r <= pre_cnt_r + 8'h01;
			if (tick_a)
				sa_cnt_r <= tick_sa ? 9'h000 : sa_cnt_r + 9'h001;
			if (tick_b)
				sb_cnt_r <= tick_sb ? 9'h000 : sb_cnt_r + 9'h001;
		end
	end

	// channels 2 and 3 run from the B family, the rest from A
	always @* begin
		for (it = 0; it < NCH; it = it + 1) begin
			if (it == 2 || it == 3)
				tick_ch[it] = clksel_r[it] ? tick_sb : tick_b;
			else
				tick_ch[it] = clksel_r[it] ? tick_sa : tick_a;
		end
	end

	// apb decode
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pready_r & pwrite;
	assign grp    = paddr[7:5];
	assign idx    = paddr[4:2];
	assign idx_ok = (idx < NCH);

	always @* begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		// misaligned access refused before any decode
		if (paddr[1:0] != 2'b00)
			rd_err = 1'b1;
		else if (grp == 3'h0) begin
			case (paddr[7:0])
			`PWMC_OFS_ENABLE:   rd_val[NCH-1:0] = enable_r;
			`PWMC_OFS_POLAR:    rd_val[NCH-1:0] = polar_r;
			`PWMC_OFS_CLKSEL:   rd_val[NCH-1:0] = clksel_r;
			`PWMC_OFS_PRESCALE: rd_val[7:0] = prescale_r;
			`PWMC_OFS_SCALE_A:  rd_val[7:0] = scale_a_r;
			`PWMC_OFS_SCALE_B:  rd_val[7:0] = scale_b_r;
			`PWMC_OFS_CTRL:     rd_val[7:0] = ctrl_r;
			// test register reads zero and ignores writes
			`PWMC_OFS_TEST:     rd_val = 32'h00000000;
			default:            rd_err = 1'b1;
			endcase
		end else if (idx_ok && grp == `PWMC_GRP_CNT)
			rd_val[7:0] = cnt_r[idx];
		else if (idx_ok && grp == `PWMC_GRP_PER)
			rd_val[7:0] = per_buf_r[idx];
		else if (idx_ok && grp == `PWMC_GRP_DTY)
			rd_val[7:0] = dty_buf_r[idx];
		else
			rd_err = 1'b1;
	end

	// no wait state: data and error are latched in the setup cycle
	always @(posedge clk) begin
		if (!resetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & rd_err;
			if (setup)
				prdata_r <= pwrite ? 32'h00000000 : rd_val;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			enable_r   <= {NCH{1'b0}};
			polar_r    <= {NCH{1'b0}};
			clksel_r   <= {NCH{1'b0}};
			prescale_r <= `PWMC_RST_BYTE;
			scale_a_r  <= `PWMC_RST_BYTE;
			scale_b_r  <= `PWMC_RST_BYTE;
			ctrl_r     <= `PWMC_RST_BYTE;
			for (iw = 0; iw < NCH; iw = iw + 1) begin
				per_buf_r[iw] <= `PWMC_RST_PER;
				dty_buf_r[iw] <= `PWMC_RST_DTY;
			end
		end else if (wr_en && !pslverr_r) begin
			case (paddr[7:0])
			`PWMC_OFS_ENABLE:   enable_r   <= pwdata[NCH-1:0];
			`PWMC_OFS_POLAR:    polar_r    <= pwdata[NCH-1:0];
			`PWMC_OFS_CLKSEL:   clksel_r   <= pwdata[NCH-1:0];
			`PWMC_OFS_PRESCALE: prescale_r <= pwdata[7:0] & `PWMC_PRE_MASK;
			`PWMC_OFS_SCALE_A:  scale_a_r  <= pwdata[7:0];
			`PWMC_OFS_SCALE_B:  scale_b_r  <= pwdata[7:0];
			`PWMC_OFS_CTRL:     ctrl_r     <= pwdata[7:0] & `PWMC_CTRL_MASK;
			// test register lands here too and is dropped
			default: begin
				if (idx_ok && grp == `PWMC_GRP_PER)
					per_buf_r[idx] <= pwdata[7:0];
				if (idx_ok && grp == `PWMC_GRP_DTY)
					dty_buf_r[idx] <= pwdata[7:0];
			end
			endcase
		end
	end

	// a write to a counter restarts that channel's period
	always @* begin
		for (ic = 0; ic < NCH; ic = ic + 1)
			cnt_clr[ic] = wr_en && !pslverr_r && grp == `PWMC_GRP_CNT &&
				idx == ic;
	end

	// even channel of a joined pair is the high byte; the odd
	// channel's tick, enable and polarity steer the whole pair
	always @* begin
		st          = 49'h0;
		pwm_out_nxt = {NCH{1'b0}};
		for (i = 0; i < NCH; i = i + 1) begin
			cnt_nxt[i]     = cnt_r[i];
			per_act_nxt[i] = per_act_r[i];
			dty_act_nxt[i] = dty_act_r[i];
		end
		for (k = 0; k < NCH/2; k = k + 1) begin
			e = 2 * k;
			o = e + 1;
			if (join_w[k]) begin
				st = fn_step({cnt_r[e], cnt_r[o]},
					{per_act_r[e], per_act_r[o]},
					{dty_act_r[e], dty_act_r[o]},
					{per_buf_r[e], per_buf_r[o]},
					{dty_buf_r[e], dty_buf_r[o]},
					pwm_out_r[o], tick_ch[o], enable_r[o], polar_r[o],
					cnt_clr[e] | cnt_clr[o]);
				{cnt_nxt[e], cnt_nxt[o]}         = st[48:33];
				{per_act_nxt[e], per_act_nxt[o]} = st[32:17];
				{dty_act_nxt[e], dty_act_nxt[o]} = st[16:1];
				pwm_out_nxt[o]                   = st[0];
				pwm_out_nxt[e]                   = 1'b0;
			end else begin
				for (i = e; i <= o; i = i + 1) begin
					st = fn_step({8'h00, cnt_r[i]}, {8'h00, per_act_r[i]},
						{8'h00, dty_act_r[i]}, {8'h00, per_buf_r[i]},
						{8'h00, dty_buf_r[i]}, pwm_out_r[i], tick_ch[i],
						enable_r[i], polar_r[i], cnt_clr[i]);
					cnt_nxt[i]     = st[40:33];
					per_act_nxt[i] = st[24:17];
					dty_act_nxt[i] = st[8:1];
					pwm_out_nxt[i] = st[0];
				end
			end
		end
	end

	// pins straight from flops, so no decode glitch reaches them
	always @(posedge clk) begin
		if (!resetn) begin
			pwm_out_r <= {NCH{1'b0}};
			for (io = 0; io < NCH; io = io + 1) begin
				cnt_r[io]     <= `PWMC_RST_BYTE;
				per_act_r[io] <= `PWMC_RST_PER;
				dty_act_r[io] <= `PWMC_RST_DTY;
			end
		end else begin
			pwm_out_r <= pwm_out_nxt;
			for (io = 0; io < NCH; io = io + 1) begin
				cnt_r[io]     <= cnt_nxt[io];
				per_act_r[io] <= per_act_nxt[io];
				dty_act_r[io] <= dty_act_nxt[io];
			end
		end
	end

endmodule // pwmc_top

// ### pwmc_consts.vh
// constants for the concatenating left-aligned modulator
`ifndef PWMC_CONSTS_VH
`define PWMC_CONSTS_VH
`define PWMC_OFS_ENABLE   8'h00
`define PWMC_OFS_POLAR    8'h04
`define PWMC_OFS_CLKSEL   8'h08
`define PWMC_OFS_PRESCALE 8'h0C
`define PWMC_OFS_SCALE_A  8'h10
`define PWMC_OFS_SCALE_B  8'h14
`define PWMC_OFS_CTRL     8'h18
`define PWMC_OFS_TEST     8'h1C
`define PWMC_GRP_CNT      3'h1
`define PWMC_GRP_PER      3'h2
`define PWMC_GRP_DTY      3'h3
`define PWMC_BIT_JOIN_HI  6
`define PWMC_BIT_JOIN_MID 5
`define PWMC_BIT_JOIN_LO  4
`define PWMC_BIT_WAIT     3
`define PWMC_BIT_FREEZE   2
`define PWMC_CTRL_MASK    8'h7C
`define PWMC_PRE_A_LSB    0
`define PWMC_PRE_B_LSB    4
`define PWMC_PRE_MASK     8'h77
`define PWMC_RST_PER      8'hFF
`define PWMC_RST_DTY      8'hFF
`define PWMC_RST_BYTE     8'h00
`define PWMC_SCL_ZERO_LIM 9'h1FF
`endif

// ### pwmc_top_properties.sv
// concurrent checks on the modulator bus and output pins
`timescale 1ns/1ps
module pwmc_top_properties #(
	parameter NCH    = 6,
	parameter ADDR_W = 8
) (
	input logic              clk,
	input logic              resetn,
	input logic              psel,
	input logic              penable,
	input logic              pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       pwdata,
	input logic [31:0]       prdata_r,
	input logic              pready_r,
	input logic              pslverr_r,
	input logic              wait_mode,
	input logic              freeze_mode,
	input logic [NCH-1:0]    pwm_out_r
);
	// control mirror from completed writes, since the checker sees pins only
	logic [6:2] ctl_r;
	logic       gw;
	logic       gf;
	assign gw = wait_mode && ctl_r[3];
	assign gf = freeze_mode && ctl_r[2];
	always_ff @(posedge clk)
		if (!resetn)
			ctl_r <= 5'h00;
		else if (psel && penable && pready_r && pwrite && paddr == 8'h18)
			ctl_r <= pwdata[6:2];
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_ready_setup: assert property (psel && !penable |=> pready_r)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready_r |=> !pready_r)
		else $error("ready held too long");
	chk_err_data: assert property (pslverr_r |-> pready_r && prdata_r == 32'h0)
		else $error("error without ready or with data");
	chk_test_hidden:
		assert property (pready_r && paddr == 8'h1C |-> !pslverr_r && !prdata_r)
		else $error("test register visible");
	chk_hi_even: assert property (ctl_r[6] && $past(ctl_r[6]) |-> !pwm_out_r[4])
		else $error("pin 4 driven while joined");
	chk_mid_even: assert property (ctl_r[5] && $past(ctl_r[5]) |-> !pwm_out_r[2])
		else $error("pin 2 driven while joined");
	chk_lo_even: assert property (ctl_r[4] && $past(ctl_r[4]) |-> !pwm_out_r[0])
		else $error("pin 0 driven while joined");
	chk_wait_hold:
		assert property (gw && $past(gw) && $past(gw, 2) |-> $stable(pwm_out_r))
		else $error("outputs moved in wait");
	chk_frz_hold:
		assert property (gf && $past(gf) && $past(gf, 2) |-> $stable(pwm_out_r))
		else $error("outputs moved in freeze");
	cov_wait: cover property (gw);
	cov_frz: cover property (gf);
	cov_err: cover property (pslverr_r);
endmodule // pwmc_top_properties

bind pwmc_top pwmc_top_properties #(.NCH(NCH), .ADDR_W(ADDR_W)) u_props (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
	.pready_r(pready_r), .pslverr_r(pslverr_r), .wait_mode(wait_mode),
	.freeze_mode(freeze_mode), .pwm_out_r(pwm_out_r));

// ### pwmc_top_test.sv
// self-checking bench for the left-aligned modulator
`timescale 1ns/1ps
module pwmc_top_test;
	logic        clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        wait_mode;
	logic        freeze_mode;
	logic [5:0]  pwm_out_r;
	logic [31:0] rd;
	logic [31:0] rb;
	logic        er;
	int          miscompares = 0;
	int          cmp_count = 0;

	pwmc_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r), .wait_mode(wait_mode),
		.freeze_mode(freeze_mode), .pwm_out_r(pwm_out_r));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// one idle edge first, so a release never meets a new request
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready_r !== 1'b1);
		rd = prdata_r;
		er = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic cfg(input int c, input logic [7:0] p, input logic [7:0] t);
		wr(8'(8'h40 + 4 * c), {24'h0, p});
		wr(8'(8'h60 + 4 * c), {24'h0, t});
	endtask

	task automatic meas(input int c, input int n, input int e);
		int h;
		h = 0;
		repeat (n) begin
			@(posedge clk);
			h += (pwm_out_r[c] === 1'b1);
		end
		cmp("high ticks", e, h);
	endtask

	task automatic t_regs;
		rdr(8'h18);
		cmp("ctrl reset", 32'h0, rd);
		wr(8'h18, 32'hFF);
		rdr(8'h18);
		cmp("ctrl bits", 32'h7C, rd);
		wr(8'h1C, 32'hFF);
		rdr(8'h1C);
		cmp("test reg", 32'h0, {er, rd[30:0]});
		rdr(8'h84);
		cmp("unmapped err", 32'h1, {31'h0, er});
		wr(8'h18, 32'h00);
	endtask

	task automatic t_left;
		for (int p = 0; p < 2; p++) begin
			wr(8'h04, p ? 32'h03 : 32'h00);
			cfg(0, 4, 1);
			cfg(1, 6, 2);
			wr(8'h00, 32'h03);
			repeat (12) @(posedge clk);
			meas(0, 8, p ? 2 : 6);
			meas(1, 12, p ? 4 : 8);
			wr(8'h00, 32'h00);
		end
		wr(8'h04, 32'h00);
	endtask

	task automatic t_join;
		for (int q = 0; q < 3; q++) begin
			wr(8'h18, 32'h10 << q);
			cfg(2 * q, 1, 0);
			cfg(2 * q + 1, 0, 8'h40);
			wr(8'h00, 32'h02 << (2 * q));
			repeat (300) @(posedge clk);
			meas(2 * q + 1, 512, 384);
			wr(8'h00, 32'h03 << (2 * q));
			repeat (2) @(posedge clk);
			cmp("even pin", 32'h0, pwm_out_r[2 * q]);
			wr(8'h00, 32'h00);
		end
		wr(8'h18, 32'h00);
	endtask

	task automatic t_gate;
		logic [4:0] tc [4] = '{5'h15, 5'h0B, 5'h06, 5'h12};
		cfg(0, 4, 1);
		wr(8'h00, 32'h01);
		foreach (tc[i]) begin
			wr(8'h18, {28'h0, tc[i][4:3], 2'h0});
			wait_mode <= tc[i][2];
			freeze_mode <= tc[i][1];
			rdr(8'h20);
			rb = rd;
			rdr(8'h20);
			cmp("count held", {31'h0, tc[i][0]}, {31'h0, rb === rd});
			wait_mode <= 1'b0;
			freeze_mode <= 1'b0;
		end
		wr(8'h00, 32'h00);
	endtask

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wait_mode = 1'b0;
		freeze_mode = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_regs;
		t_left;
		t_join;
		t_gate;
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end
endmodule // pwmc_top_test
